// [rtl/chg_evt.sv]
// Change and fresh-value event detection for one input object
`timescale 1ns/1ns
`include "chg_evt_map.svh"
// Summary of operation
// RULE_01 - Events sample input implicitly, inputs only
// RULE_02 - Plain change: sample differs from reference
// RULE_03 - Reference reloads only when change fires
// RULE_04 - Magnitude form: abs difference meets threshold
// RULE_05 - Target form: sample becomes target value
// RULE_06 - Counter sources: new and different only; dual-slope here needs only a new one
// RULE_07 - Dual-slope change on conversion complete
// RULE_08 - High-time, period change when duration differs
// RULE_09 - Count, quadrature change when count differs
// RULE_10 - Fresh event on update, counter modes only
// RULE_11 - Dual-slope fresh: complete and result differs
// RULE_12 - High-time, period fresh at interval end
// RULE_13 - Edge-count fresh once per latch interval
// RULE_14 - Quadrature fresh once a count accumulates
// RULE_15 - Present triggering sample as signed value
// RULE_16 - Consumer trusts sample only after event
// RULE_17 - Consumer may preset the reference value
// RULE_18 - Edge-count latches every 2^23 reference periods
// RULE_19 - Event pulse coincides with sample update
module chg_evt #(
  parameter int unsigned W      = `SAMPLE_W,
  parameter int unsigned LATCH  = `LATCH_CYCLES
) (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  // Configuration
  input  wire chg_evt_pkg::src_mode_t i_src_mode,
  input  wire chg_evt_pkg::chg_mode_t i_chg_mode,
  input  wire logic signed [W-1:0]   i_threshold,
  input  wire logic signed [W-1:0]   i_target,
  // Reference preset by the consumer
  input  wire logic                  i_ref_load,
  input  wire logic signed [W-1:0]   i_ref_value,
  // Measurement source
  input  wire logic signed [W-1:0]   i_sample,
  input  wire logic                  i_meas_valid,
  input  wire logic                  i_count_edge,
  // Events and presented value
  output logic                       o_change,
  output logic                       o_update,
  output logic signed [W-1:0]        o_value,
  output logic                       o_latch
);
  // Absolute difference, computed one bit wider to avoid overflow
  function automatic logic [W:0] abs_diff(input logic signed [W-1:0] a,
                                          input logic signed [W-1:0] b);
    logic signed [W:0] d;
    d = {a[W-1], a} - {b[W-1], b};
    return d[W] ? (W+1)'(-d) : d;
  endfunction

  logic signed [W-1:0] ref_val;    // Reference for change comparison
  logic signed [W-1:0] prev_meas;  // Last delivered measurement
  logic signed [W-1:0] prev_smp;   // Previous sample, for the target form
  logic                tick;       // Latch interval tick

  // Latch interval generator for edge-count sources
  latch_timer #(
    .CYCLES (LATCH)
  ) u_latch (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  // Source classification
  wire is_direct = (i_src_mode == chg_evt_pkg::SRC_DIRECT);
  wire is_count  = (i_src_mode == chg_evt_pkg::SRC_COUNT);
  wire is_quad   = (i_src_mode == chg_evt_pkg::SRC_QUAD);
  wire is_dual   = (i_src_mode == chg_evt_pkg::SRC_DUAL);
  wire is_dur    = (i_src_mode == chg_evt_pkg::SRC_ONTIME) ||
                   (i_src_mode == chg_evt_pkg::SRC_PERIOD);

  // New measurement delivered this cycle, per source kind
  wire fresh_cnt = is_count && tick;                              // RULE_13 RULE_18
  // A quadrature edge is itself a fresh count; nothing is held back
  wire fresh_q   = is_quad && i_count_edge;                        // RULE_14
  wire new_meas  = is_direct || fresh_cnt || fresh_q ||
                   ((is_dual || is_dur) && i_meas_valid);          // RULE_01
  wire meas_diff = (i_sample != prev_meas);

  // Change qualifiers against the reference or the target
  wire diff_any  = (i_sample != ref_val);                          // RULE_02
  wire diff_by   = (abs_diff(i_sample, ref_val) >=
                    {1'b0, $unsigned(i_threshold)});               // RULE_04
  wire diff_to   = (i_sample == i_target) && (prev_smp != i_target); // RULE_05
  wire qual_ok   = (i_chg_mode == chg_evt_pkg::CHG_BY) ? diff_by :
                   (i_chg_mode == chg_evt_pkg::CHG_TO) ? diff_to : diff_any;

  // Counter sources except dual-slope need new and different; direct needs only a sample, dual-slope only a new one
  wire fire_chg  = new_meas && qual_ok &&
                   (is_direct || is_dual || meas_diff);            // RULE_06 RULE_07 RULE_08 RULE_09
  // Fresh event only for counter modes
  wire fire_upd  = (is_dual && i_meas_valid && meas_diff) ||       // RULE_11
                   (is_dur && i_meas_valid) ||                     // RULE_12
                   fresh_cnt || fresh_q;                           // RULE_10

  // Reference register: preset wins only when no change reloads it
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ref_val <= W'(`REF_RESET);
    else if (fire_chg)
      ref_val <= i_sample;                                         // RULE_03
    else if (i_ref_load)
      ref_val <= i_ref_value;
  end

  // Previous measurement and sample history
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prev_meas <= W'(`REF_RESET);
      prev_smp  <= W'(`REF_RESET);
    end
    else
    begin
      prev_smp <= new_meas ? i_sample : prev_smp;
      prev_meas <= new_meas ? i_sample : prev_meas;
    end
  end

  // Registered events with the value that caused them
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_change <= 1'b0;
      o_update <= 1'b0;
      o_value  <= '0;
      o_latch  <= 1'b0;
    end
    else
    begin
      o_change <= fire_chg;                                        // RULE_19
      o_update <= fire_upd;                                        // RULE_19
      o_latch  <= tick;
      if (fire_chg || fire_upd)
        o_value <= i_sample;                                       // RULE_15
    end
  end

  // Checks on the reference and the event outputs
  ref_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_03
    (!fire_chg && !i_ref_load) |=> $stable(ref_val))
    else $error("reference moved without a change");
  ref_load_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_03
    fire_chg |=> (ref_val == $past(i_sample)))
    else $error("reference not reloaded on change");
  value_match_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_15
    (fire_chg || fire_upd) |=> (o_value == $past(i_sample)))
    else $error("presented value not the trigger sample");
  chg_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_19
    fire_chg |=> o_change)
    else $error("change pulse missing");
  stale_block_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_08
    (is_dur && i_meas_valid && !meas_diff) |=> !o_change)
    else $error("change fired on stale duration");
  count_diff_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_09
    (is_count && !meas_diff) |=> !o_change)
    else $error("change fired on equal count");
  upd_dir_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_10
    is_direct |=> !o_update)
    else $error("update event on direct input");
  dual_upd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_11
    (is_dual && i_meas_valid && meas_diff) |=> o_update)
    else $error("dual-slope update missing");
  dur_upd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_12
    (is_dur && i_meas_valid) |=> o_update)
    else $error("interval end update missing");
  cnt_upd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_13
    (is_count && !tick) |=> !o_update)
    else $error("edge-count update off interval");
  to_form_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_05
    (i_chg_mode == chg_evt_pkg::CHG_TO && is_direct && i_sample != i_target)
      |=> !o_change)
    else $error("target change without target value");
  // Every quadrature edge must surface as a fresh value next cycle
  quad_upd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_14
    (is_quad && i_count_edge) |=> o_update)
    else $error("quadrature update missing");
  // The latch tick must give both the update and the latch pulse
  cnt_tick_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_13
    (is_count && tick) |=> (o_update && o_latch))
    else $error("edge-count update missing at latch");

  // Main scenarios
  cov_change_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_change);
  cov_update_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_update);
  cov_by_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    fire_chg && i_chg_mode == chg_evt_pkg::CHG_BY);
  cov_both_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    fire_chg && fire_upd);
endmodule

// [shared/chg_evt_map.svh]
// Constants for the input change and update event block
`ifndef CHG_EVT_MAP_SVH
`define CHG_EVT_MAP_SVH
// Clock rate of the block in MHz
`define CLK_MHZ           20
// Edge-count latch interval: 2^23 periods of a 10 MHz reference clock
`define LATCH_REF_MHZ     10
`define LATCH_REF_PERIODS 8388608
// Latch interval in cycles of the block clock (exact, 16777216)
`define LATCH_CYCLES      ((`LATCH_REF_PERIODS * `CLK_MHZ) / `LATCH_REF_MHZ)
// Default sample width (signed 16-bit)
`define SAMPLE_W          16
// Reset value of the stored reference
`define REF_RESET         16'h0000
`endif

// [shared/chg_evt_pkg.sv]
// Types for the input change and update event block
package chg_evt_pkg;
  // Measurement source kinds
  typedef enum logic [2:0]
  {
    SRC_DIRECT  = 3'h0,
    SRC_DUAL    = 3'h1,
    SRC_ONTIME  = 3'h2,
    SRC_PERIOD  = 3'h3,
    SRC_COUNT   = 3'h4,
    SRC_QUAD    = 3'h5
  } src_mode_t;
  // Change qualifier kinds
  typedef enum logic [1:0]
  {
    CHG_ANY     = 2'h0,
    CHG_BY      = 2'h1,
    CHG_TO      = 2'h2
  } chg_mode_t;
endpackage

// [rtl/latch_timer.sv]
// Free-running latch interval timer for edge-count mode
`timescale 1ns/1ns
`include "chg_evt_map.svh"
module latch_timer #(
  parameter int unsigned CYCLES = `LATCH_CYCLES
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Tick output, one cycle per interval
  output logic      o_tick
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  logic [W-1:0] count;      // Cycles elapsed in the interval
  wire          at_end = (count == W'(CYCLES - 1));
  // Count and wrap; the tick is registered so it lines up cleanly
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count  <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      count  <= at_end ? '0 : count + W'(1);
      o_tick <= at_end;
    end
  end
endmodule

// [sim/meas_src.sv]
// Behavioural measurement source feeding the event block
`timescale 1ns/1ns
module meas_src (
  // Clock
  input  wire logic          i_mclk,
  // Source outputs
  output logic signed [15:0] o_sample,
  output logic               o_valid,
  output logic               o_edge
);
  initial
  begin
    o_sample = 16'sh0000;
    o_valid  = 1'b0;
    o_edge   = 1'b0;
  end
  // One measurement with a one-cycle strobe, then a stale value
  task automatic give(input logic signed [15:0] v, input bit quad);
    @(negedge i_mclk);
    o_sample <= v;
    o_valid  <= !quad;
    o_edge   <= quad;
    @(negedge i_mclk);
    o_valid  <= 1'b0;
    o_edge   <= 1'b0;
    // Stale value differs on purpose; only an edge-count latch may take it
    o_sample <= ~v;
  endtask
endmodule

// [sim/tb_chg_evt.sv]
// Self-checking bench for the change and fresh-value event block
`timescale 1ns/1ns
module tb_chg_evt;
  // Short latch interval keeps the run brief
  localparam int L = 16;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  chg_evt_pkg::src_mode_t src = chg_evt_pkg::SRC_DIRECT;
  chg_evt_pkg::chg_mode_t cm = chg_evt_pkg::CHG_ANY;
  logic signed [15:0] thr = 16'h0000, tgt = 16'h0003, rv = 16'h0000, ds = 16'h0000;
  logic signed [15:0] ms, val, rf, pv, ps, hv, v;
  logic ld = 1'b0, use_src = 1'b0;
  logic mv, ce, chg, upd, lat, e;
  int num_errors = 0, compares = 0, seed = 32'h6071013b, n, k, nl, nu;
  always #25 i_mclk = ~i_mclk;
  chg_evt #(.W(16), .LATCH(L)) dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_src_mode(src), .i_chg_mode(cm),
    .i_threshold(thr), .i_target(tgt), .i_ref_load(ld), .i_ref_value(rv),
    .i_sample(use_src ? ms : ds), .i_meas_valid(mv), .i_count_edge(ce),
    .o_change(chg), .o_update(upd), .o_value(val), .o_latch(lat));
  meas_src src_i (.i_mclk(i_mclk), .o_sample(ms), .o_valid(mv), .o_edge(ce));
  // Compare one value against its expectation
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Four-cycle reset, then change, update and value must read zero
  task automatic do_reset;
    ds = 16'h0000;
    ld = 1'b0;
    i_rst_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    i_rst_n = 1'b1;
    {rf, pv, ps, hv} = '0;
    check(chg, 1'b0);
    check(upd, 1'b0);
    check(val, 16'h0000);
  endtask
  // Expected change for a direct source
  function automatic logic exp_chg(chg_evt_pkg::chg_mode_t f, logic signed [15:0] s);
    int d;
    d = s - rf;
    if (d < 0) d = -d;
    case (f)
      chg_evt_pkg::CHG_ANY: return s != rf;
      chg_evt_pkg::CHG_BY:  return d >= thr;
      default:              return s == tgt && ps != tgt;
    endcase
  endfunction
  // Random direct samples, threshold moving every cycle, random presets
  task automatic direct(input chg_evt_pkg::chg_mode_t f);
    do_reset();
    use_src = 1'b0;
    src = chg_evt_pkg::SRC_DIRECT;
    cm = f;
    // Target drawn per run so the target form is not tied to one value
    tgt = 16'($random(seed) % 4);
    repeat (60)
    begin
      ds = 16'($random(seed) % 8);
      thr = {13'h0000, 3'($random(seed))};
      ld = ($random(seed) & 7) == 0;
      rv = 16'($random(seed) % 8);
      e = exp_chg(f, ds);
      @(negedge i_mclk);
      check(chg, e);
      check(upd, 1'b0);
      if (e) hv = ds;
      check(val, hv);
      // Preset only sticks when no change reloads the reference
      if (e) rf = ds;
      else if (ld) rf = rv;
      ps = ds;
    end
    ld = 1'b0;
    $display("Direct form %0d done", f);
  endtask
  // Counter sources: strobed measurements with idle gaps between
  task automatic counter(input chg_evt_pkg::src_mode_t m);
    do_reset();
    src = m;
    cm = chg_evt_pkg::CHG_ANY;
    use_src = 1'b1;
    repeat (12)
    begin
      v = 16'($random(seed) % 3);
      src_i.give(v, m == chg_evt_pkg::SRC_QUAD);
      check(upd, m != chg_evt_pkg::SRC_DUAL || v != pv);
      // Change still needs a value unlike the reference, which tracks pv
      if (m == chg_evt_pkg::SRC_DUAL) check(chg, v != pv);
      else if (m == chg_evt_pkg::SRC_QUAD) check(chg, v != pv);
      else check(chg, v != pv);
      check(val, v);
      pv = v;
      n = $random(seed) & 3;
      repeat (n)
      begin
        @(negedge i_mclk);
        check(chg | upd, 1'b0);
      end
    end
    $display("Source mode %0d done", m);
  endtask
  initial
  begin
    direct(chg_evt_pkg::CHG_ANY);
    direct(chg_evt_pkg::CHG_BY);
    direct(chg_evt_pkg::CHG_TO);
    counter(chg_evt_pkg::SRC_DUAL);
    counter(chg_evt_pkg::SRC_ONTIME);
    counter(chg_evt_pkg::SRC_PERIOD);
    counter(chg_evt_pkg::SRC_QUAD);
    // Edge count: one fresh event per latch interval
    do_reset();
    src = chg_evt_pkg::SRC_COUNT;
    src_i.give(16'h0005, 1'b1);
    k = 0;
    while (lat !== 1'b1 && k < 2 * L)
    begin
      @(negedge i_mclk);
      k++;
    end
    check(lat, 1'b1);
    {nl, nu} = '0;
    repeat (3 * L)
    begin
      @(negedge i_mclk);
      nl += (lat === 1'b1);
      nu += (upd === 1'b1);
    end
    check(16'(nl), 16'h0003);
    check(16'(nu), 16'h0003);
    check(val, 16'hfffa);
    $display("Edge count done");
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #(50 * 3000);
    num_errors++;
    conclude();
  end
endmodule
